/* File: sim/dpot_master.sv */
// Bus master model that clocks the two-wire link of the potentiometer slave.
`timescale 1ns/100ps
module dpot_master (
    input wire logic clock,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    // ********************************
    // Link driver, bit and byte tasks
    // ********************************
    // The clock line rests high between frames and only this model moves it.
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // Data moves a clock after the clock line falls, so the slave never sees it race.
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_low = ~b;
        tick(3);
        scl = 1'b1;
        tick(2);
        r = sda_line;
        tick(2);
        scl = 1'b0;
    endtask : bit_io

    // Also serves as a repeated start, so data is released before the clock rises.
    task automatic start();
        tick(1);
        sda_low = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(2);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b0;
    endtask : start

    // Only issued once the slave has released the data line.
    task automatic stop();
        tick(1);
        sda_low = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(2);
        sda_low = 1'b0;
        tick(2);
    endtask : stop

    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send

    task automatic recv(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~ack, r);
    endtask : recv
endmodule : dpot_master

/* File: sim/dpot_slave_props.sv */
// Concurrent checks on the pins of the two-wire potentiometer slave.
`timescale 1ns/100ps
module dpot_slave_props #(
    parameter logic [3:0] TYPE_ID = 4'hA,
    parameter int PROG_CYCLES = 100000
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic chip_select,
    input wire logic write_protect_n,
    input wire logic [2:0] address_strap_pins,
    input wire dpot_pkg::dpot_wipers_t wipers,
    input wire logic nv_busy
);
    // ********************************
    // Helper logic and assertions
    // ********************************
    logic [31:0] busy_run_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    always_ff @(posedge clock)
    begin
        if (reset || !nv_busy)
            busy_run_reg <= 32'h0;
        else
            busy_run_reg <= busy_run_reg + 32'h1;
    end

    sequence s_cs_off;
        !chip_select [*4];
    endsequence
    sequence s_wp_low;
        !write_protect_n [*4];
    endsequence

    a_out_low: assert property (sda_out == 1'b0)
        else $error("data pin drives a high level");
    a_reset_release: assert property ($fell(reset) |-> !sda_oe && !nv_busy)
        else $error("data pin or busy active after reset");
    a_reset_wipers: assert property ($fell(reset) |-> wipers == 32'h80808080)
        else $error("wipers not at level zero after reset");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed while clock high");
    a_cs_quiet: assert property (s_cs_off |=> !sda_oe)
        else $error("data driven while deselected");
    a_busy_len: assert property ($fell(nv_busy) |-> busy_run_reg == PROG_CYCLES)
        else $error("programming cycle length wrong");
    a_busy_quiet: assert property (nv_busy |-> !sda_oe)
        else $error("acknowledge given while programming");
    a_wp_no_prog: assert property (s_wp_low |-> !$rose(nv_busy))
        else $error("programming started while protected");
    a_wiper_scl_low: assert property ($changed(wipers) |-> !scl_in)
        else $error("wiper changed while clock high");
endmodule : dpot_slave_props

bind dpot_slave dpot_slave_props #(.TYPE_ID(TYPE_ID), .PROG_CYCLES(PROG_CYCLES)) u_dpot_slave_props (
    .clock(clock),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .chip_select(chip_select),
    .write_protect_n(write_protect_n),
    .address_strap_pins(address_strap_pins),
    .wipers(wipers),
    .nv_busy(nv_busy)
);

/* File: sim/test_dpot_slave.sv */
// Self-checking bench of the two-wire potentiometer slave.
`timescale 1ns/100ps
module test_dpot_slave;
    // ********************************
    // Set-up, link wiring and tasks
    // ********************************
    // Type identifier value is arbitrary.
    localparam logic [3:0] TID = 4'hA;
    localparam logic [2:0] STRAP = 3'h5;
    logic clock, reset, chip_select, write_protect_n, sda_oe, sda_out, nv_busy;
    logic scl, sda_low, sda_line;
    dpot_pkg::dpot_wipers_t wipers;
    logic [2:0] strap_pins;
    int n_errors = 0;
    int n_checks = 0;
    // Open-drain wire with a pull-up.
    assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;

    dpot_slave #(.TYPE_ID(TID), .PROG_CYCLES(200)) u_dpot_slave (
        .clock(clock),
        .reset(reset),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .chip_select(chip_select),
        .write_protect_n(write_protect_n),
        .address_strap_pins(strap_pins),
        .wipers(wipers),
        .nv_busy(nv_busy)
    );
    dpot_master u_dpot_master (
        .clock(clock),
        .sda_line(sda_line),
        .scl(scl),
        .sda_low(sda_low)
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic probe(input logic [7:0] sa, output logic k);
        u_dpot_master.start();
        u_dpot_master.send(sa, k);
        u_dpot_master.stop();
    endtask : probe

    task automatic open_at(input logic [2:0] a);
        logic k;
        u_dpot_master.start();
        u_dpot_master.send({TID, STRAP, 1'b0}, k);
        check("slave ack", k, 1'b1);
        u_dpot_master.send({5'h00, a}, k);
        check("byte addr ack", k, 1'b1);
    endtask : open_at

    task automatic put(input logic [7:0] d);
        logic k;
        u_dpot_master.send(d, k);
        check("data ack", k, 1'b1);
    endtask : put

    // Selection goes first in a transfer of its own.
    task automatic sel(input logic [7:0] d);
        open_at(3'h7);
        put(d);
        u_dpot_master.stop();
    endtask : sel

    task automatic get_at(input logic [2:0] a, input int n, output logic [31:0] q);
        logic k;
        open_at(a);
        u_dpot_master.start();
        u_dpot_master.send({TID, STRAP, 1'b1}, k);
        check("read ack", k, 1'b1);
        for (int i = 0; i < n; i++)
            u_dpot_master.recv(i < n - 1, q[8 * i +: 8]);
        u_dpot_master.stop();
    endtask : get_at

    initial
    begin
        #2000000;
        n_errors++;
        complete_run();
    end

    // ********************************
    // Test sequence
    // ********************************
    initial
    begin
        logic k;
        logic [31:0] q;
        logic [7:0] bad [3];
        reset = 1'b1;
        strap_pins = STRAP;
        chip_select = 1'b1;
        write_protect_n = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        reset = 1'b0;
        u_dpot_master.tick(3);
        check("oe", sda_oe, 1'b0);
        check("wipers", wipers, 32'h80808080);
        get_at(3'h7, 1, q);
        check("select", q[7:0], 8'h00);
        get_at(3'h5, 1, q);
        check("unused", q[7:0], 8'h00);
        $display("test reset done");
        open_at(3'h0);
        for (int i = 1; i < 6; i++)
            put(8'(i * 17));
        u_dpot_master.stop();
        check("page", wipers, 32'h44332255);
        open_at(3'h2);
        put(8'h66);
        u_dpot_master.stop();
        check("single", wipers, 32'h44662255);
        get_at(3'h0, 4, q);
        check("burst read", q, 32'h44662255);
        // Held for several clocks so the flushed synchronisers never see a false edge.
        reset = 1'b1;
        u_dpot_master.tick(4);
        reset = 1'b0;
        u_dpot_master.tick(3);
        check("reset oe", sda_oe, 1'b0);
        check("reset wipers", wipers, 32'h80808080);
        $display("test wipers done");
        bad[0] = {TID, STRAP ^ 3'h1, 1'b0};
        bad[1] = {TID ^ 4'h8, STRAP, 1'b0};
        bad[2] = {TID, STRAP ^ 3'h4, 1'b1};
        foreach (bad[i])
        begin
            probe(bad[i], k);
            check("mismatch", k, 1'b0);
        end
        chip_select = 1'b0;
        probe({TID, STRAP, 1'b0}, k);
        check("deselected", k, 1'b0);
        chip_select = 1'b1;
        strap_pins = STRAP ^ 3'h2;
        probe({TID, STRAP, 1'b0}, k);
        check("old strap", k, 1'b0);
        probe({TID, STRAP ^ 3'h2, 1'b0}, k);
        check("new strap", k, 1'b1);
        strap_pins = STRAP;
        $display("test address done");
        sel(8'h03);
        check("copy l1", wipers, 32'h80808080);
        open_at(3'h2);
        put(8'h3A);
        u_dpot_master.stop();
        check("stored to wiper", wipers, 32'h803A8080);
        u_dpot_master.tick(2);
        check("busy", nv_busy, 1'b1);
        probe({TID, STRAP, 1'b1}, k);
        check("poll busy", k, 1'b0);
        for (int i = 0; i < 10 && k !== 1'b1; i++)
            probe({TID, STRAP, 1'b0}, k);
        check("poll done", k, 1'b1);
        sel(8'h00);
        open_at(3'h2);
        put(8'h00);
        u_dpot_master.stop();
        sel(8'h03);
        check("recall l1", wipers, 32'h803A8080);
        sel(8'h05);
        check("recall l2", wipers, 32'h80808080);
        write_protect_n = 1'b0;
        open_at(3'h1);
        put(8'h5A);
        u_dpot_master.stop();
        u_dpot_master.tick(4);
        check("protected", nv_busy, 1'b0);
        check("protected wiper", wipers, 32'h80805A80);
        write_protect_n = 1'b1;
        get_at(3'h1, 1, q);
        check("stored read", q[7:0], 8'h80);
        check("read to wiper", wipers, 32'h80808080);
        sel(8'h05);
        check("discarded", wipers, 32'h80808080);
        $display("test stored done");
        complete_run();
    end
endmodule : test_dpot_slave

/* File: verilog/dpot_map.svh */
// Constants of the dual potentiometer two-wire slave.
`ifndef DPOT_MAP_SVH
`define DPOT_MAP_SVH
`define DPOT_OFS_POT0_A 3'h0
`define DPOT_OFS_POT1_B 3'h1
`define DPOT_OFS_POT1_A 3'h2
`define DPOT_OFS_POT0_B 3'h3
`define DPOT_OFS_SELECT 3'h7
`define DPOT_SELECT_RESET 8'h00
`define DPOT_STORED_INIT 8'h80
`define DPOT_BANK_BIT 0
`define DPOT_LEVEL_HI 2
`define DPOT_LEVEL_LO 1
`define DPOT_TYPE_HI 7
`define DPOT_TYPE_LO 4
`define DPOT_STRAP_HI 3
`define DPOT_STRAP_LO 1
`define DPOT_DIR_BIT 0
`define DPOT_CLK_PERIOD_NS 50
`define DPOT_PROG_TIME_NS 5000000
`define DPOT_BUSY_W 17
`endif

/* File: verilog/dpot_pkg.sv */
// Types of the dual potentiometer two-wire slave.
`include "dpot_map.svh"
package dpot_pkg;
    typedef enum logic [5:0] {
        DPOT_IDLE = 6'h01,
        DPOT_RX = 6'h02,
        DPOT_ACK = 6'h04,
        DPOT_TX = 6'h08,
        DPOT_RACK = 6'h10,
        DPOT_IGNORE = 6'h20
    } dpot_fsm_t;

    typedef enum logic [2:0] {
        DPOT_PH_SLAVE = 3'h1,
        DPOT_PH_REG = 3'h2,
        DPOT_PH_DATA = 3'h4
    } dpot_phase_t;

    typedef logic [3:0][7:0] dpot_wipers_t;

    typedef struct packed {
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [1:0] prev;
        dpot_fsm_t fsm;
        dpot_phase_t phase;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [2:0] addr;
        logic [7:0] select;
        dpot_wipers_t wiper;
        logic [15:0][7:0] stored;
        logic [3:0][7:0] pend_data;
        logic [3:0] pend_mask;
        logic acked;
        logic sda_oe;
        logic busy;
        logic [`DPOT_BUSY_W-1:0] busy_cnt;
    } dpot_state_t;
endpackage : dpot_pkg

/* File: verilog/dpot_slave.sv */
// Two-wire slave of a dual two-wiper digital potentiometer.
`timescale 1ns/100ps
`include "dpot_map.svh"
module dpot_slave #(
    // Type identifier value is arbitrary.
    parameter logic [3:0] TYPE_ID = 4'hA,
    parameter int PROG_CYCLES = `DPOT_PROG_TIME_NS / `DPOT_CLK_PERIOD_NS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_select,
    input wire logic write_protect_n,
    input wire logic [2:0] address_strap_pins,
    output dpot_pkg::dpot_wipers_t wipers,
    output logic nv_busy
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    function automatic logic [2:0] next_col(input logic [2:0] col);
        next_col = {1'b0, col[1:0] + 2'h1};
    endfunction : next_col

    function automatic logic [3:0] slot(input logic [1:0] lvl, input logic [1:0] col);
        slot = {lvl, col};
    endfunction : slot

    function automatic logic [1:0] level(input logic [7:0] sel);
        level = sel[`DPOT_LEVEL_HI:`DPOT_LEVEL_LO];
    endfunction : level

    // ****************************************************************
    // State
    // ****************************************************************

    dpot_pkg::dpot_state_t r_reg;
    dpot_pkg::dpot_state_t r_next;
    logic scl;
    logic sda;
    logic cs;
    logic wp_n;
    logic [2:0] strap;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic addr_ok;
    logic do_read;
    logic do_write;
    logic [7:0] rd_byte;

    assign scl = r_reg.sync2[6];
    assign sda = r_reg.sync2[5];
    assign cs = r_reg.sync2[4];
    assign wp_n = r_reg.sync2[3];
    assign strap = r_reg.sync2[2:0];

    // Edges are taken from the second stage against a third copy, so the
    // first stage never feeds logic and both lines see the same delay.
    assign scl_rise = scl && !r_reg.prev[1];
    assign scl_fall = !scl && r_reg.prev[1];
    assign start = scl && r_reg.prev[1] && !sda && r_reg.prev[0];
    assign stop = scl && r_reg.prev[1] && sda && !r_reg.prev[0];

    assign addr_ok = (r_reg.shift[`DPOT_TYPE_HI:`DPOT_TYPE_LO] == TYPE_ID)
        && (r_reg.shift[`DPOT_STRAP_HI:`DPOT_STRAP_LO] == strap)
        && !r_reg.busy;

    // ****************************************************************
    // Read data selection
    // ****************************************************************

    always_comb
    begin
        if (r_reg.addr == `DPOT_OFS_SELECT)
        begin
            rd_byte = r_reg.select;
        end
        else if (r_reg.addr[2])
        begin
            rd_byte = 8'h00;
        end
        else if (r_reg.select[`DPOT_BANK_BIT])
        begin
            rd_byte = r_reg.stored[slot(level(r_reg.select), r_reg.addr[1:0])];
        end
        else
        begin
            rd_byte = r_reg.wiper[r_reg.addr[1:0]];
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    always_comb
    begin
        r_next = r_reg;
        do_read = 1'b0;
        do_write = 1'b0;
        r_next.sync1 = {scl_in, sda_in, chip_select, write_protect_n, address_strap_pins};
        r_next.sync2 = r_reg.sync1;
        r_next.prev = {scl, sda};

        if (r_reg.busy)
        begin
            if (r_reg.busy_cnt <= `DPOT_BUSY_W'(1))
            begin
                r_next.busy = 1'b0;
            end
            r_next.busy_cnt = r_reg.busy_cnt - `DPOT_BUSY_W'(1);
        end

        if (!cs)
        begin
            r_next.fsm = dpot_pkg::DPOT_IDLE;
            r_next.sda_oe = 1'b0;
            r_next.pend_mask = 4'h0;
        end
        else if (start)
        begin
            r_next.fsm = dpot_pkg::DPOT_RX;
            r_next.phase = dpot_pkg::DPOT_PH_SLAVE;
            r_next.cnt = 4'h0;
            r_next.sda_oe = 1'b0;
        end
        else if (stop)
        begin
            r_next.fsm = dpot_pkg::DPOT_IDLE;
            r_next.sda_oe = 1'b0;
            r_next.pend_mask = 4'h0;
            // Bytes held for the stored bank are dropped when protected.
            if (r_reg.pend_mask != 4'h0 && wp_n)
            begin
                for (int c = 0; c < 4; c++)
                begin
                    if (r_reg.pend_mask[c])
                    begin
                        r_next.stored[slot(level(r_reg.select), 2'(c))] = r_reg.pend_data[c];
                    end
                end
                r_next.busy = 1'b1;
                r_next.busy_cnt = `DPOT_BUSY_W'(PROG_CYCLES);
            end
        end
        else
        begin
            case (r_reg.fsm)
                dpot_pkg::DPOT_RX:
                begin
                    if (scl_rise)
                    begin
                        r_next.shift = {r_reg.shift[6:0], sda};
                        r_next.cnt = r_reg.cnt + 4'h1;
                    end
                    else if (scl_fall && r_reg.cnt == 4'h8)
                    begin
                        r_next.cnt = 4'h0;
                        if (r_reg.phase == dpot_pkg::DPOT_PH_SLAVE && !addr_ok)
                        begin
                            r_next.fsm = dpot_pkg::DPOT_IGNORE;
                        end
                        else
                        begin
                            r_next.fsm = dpot_pkg::DPOT_ACK;
                            r_next.sda_oe = 1'b1;
                        end
                    end
                end
                dpot_pkg::DPOT_ACK:
                begin
                    if (scl_fall)
                    begin
                        r_next.sda_oe = 1'b0;
                        r_next.fsm = dpot_pkg::DPOT_RX;
                        case (r_reg.phase)
                            dpot_pkg::DPOT_PH_SLAVE:
                            begin
                                if (r_reg.shift[`DPOT_DIR_BIT])
                                begin
                                    do_read = 1'b1;
                                end
                                else
                                begin
                                    r_next.phase = dpot_pkg::DPOT_PH_REG;
                                end
                            end
                            dpot_pkg::DPOT_PH_REG:
                            begin
                                // Upper address bits carry no meaning.
                                r_next.addr = r_reg.shift[2:0];
                                r_next.phase = dpot_pkg::DPOT_PH_DATA;
                            end
                            dpot_pkg::DPOT_PH_DATA:
                            begin
                                do_write = 1'b1;
                            end
                            default:
                            begin
                                r_next.fsm = dpot_pkg::DPOT_IGNORE;
                            end
                        endcase
                    end
                end
                dpot_pkg::DPOT_TX:
                begin
                    if (scl_fall)
                    begin
                        if (r_reg.cnt == 4'h8)
                        begin
                            r_next.sda_oe = 1'b0;
                            r_next.fsm = dpot_pkg::DPOT_RACK;
                        end
                        else
                        begin
                            r_next.sda_oe = !r_reg.shift[7];
                            r_next.shift = {r_reg.shift[6:0], 1'b0};
                            r_next.cnt = r_reg.cnt + 4'h1;
                        end
                    end
                end
                dpot_pkg::DPOT_RACK:
                begin
                    if (scl_rise)
                    begin
                        r_next.acked = !sda;
                    end
                    else if (scl_fall)
                    begin
                        if (r_reg.acked)
                        begin
                            do_read = 1'b1;
                        end
                        else
                        begin
                            r_next.fsm = dpot_pkg::DPOT_IGNORE;
                        end
                    end
                end
                dpot_pkg::DPOT_IDLE,
                dpot_pkg::DPOT_IGNORE:
                begin
                    r_next.sda_oe = 1'b0;
                end
                default:
                begin
                    r_next.fsm = dpot_pkg::DPOT_IDLE;
                    r_next.sda_oe = 1'b0;
                end
            endcase
        end

        // ****************************************************************
        // Byte transfer side effects
        // ****************************************************************

        if (do_read)
        begin
            r_next.fsm = dpot_pkg::DPOT_TX;
            r_next.sda_oe = !rd_byte[7];
            r_next.shift = {rd_byte[6:0], 1'b0};
            r_next.cnt = 4'h1;
            if (!r_reg.addr[2])
            begin
                if (r_reg.select[`DPOT_BANK_BIT])
                begin
                    r_next.wiper[r_reg.addr[1:0]] = rd_byte;
                end
                r_next.addr = next_col(r_reg.addr);
            end
        end

        if (do_write)
        begin
            if (r_reg.addr == `DPOT_OFS_SELECT)
            begin
                r_next.select = r_reg.shift;
                if (r_reg.shift[`DPOT_BANK_BIT])
                begin
                    for (int c = 0; c < 4; c++)
                    begin
                        r_next.wiper[c] =
                            r_reg.stored[slot(level(r_reg.shift), 2'(c))];
                    end
                end
            end
            else if (!r_reg.addr[2])
            begin
                r_next.wiper[r_reg.addr[1:0]] = r_reg.shift;
                if (r_reg.select[`DPOT_BANK_BIT])
                begin
                    r_next.pend_data[r_reg.addr[1:0]] = r_reg.shift;
                    r_next.pend_mask[r_reg.addr[1:0]] = 1'b1;
                end
                r_next.addr = next_col(r_reg.addr);
            end
        end

        if (reset)
        begin
            r_next = '0;
            r_next.fsm = dpot_pkg::DPOT_IDLE;
            r_next.phase = dpot_pkg::DPOT_PH_SLAVE;
            r_next.sync1 = 7'h7F;
            r_next.sync2 = 7'h7F;
            r_next.prev = 2'h3;
            r_next.select = `DPOT_SELECT_RESET;
            r_next.sda_oe = 1'b0;
            // The stored bank is modelled by its initial image only.
            for (int i = 0; i < 16; i++)
            begin
                r_next.stored[i] = `DPOT_STORED_INIT;
            end
            for (int c = 0; c < 4; c++)
            begin
                r_next.wiper[c] = r_next.stored[slot(2'h0, 2'(c))];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        r_reg <= r_next;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Open drain: the pin is only ever pulled low.
    assign sda_out = 1'b0;
    assign sda_oe = r_reg.sda_oe;
    assign wipers = r_reg.wiper;
    assign nv_busy = r_reg.busy;

endmodule : dpot_slave
